// ### core/pio_pkg.sv
// Summary of operation
// - port a: three shared two-way pins
// - port a latch resets to all ones
// - dual-clock mode gives pins to oscillator
// - pin zero level fall sets interrupt
// - port a latch and pins separately readable
// - port a upper read bits undefined
// - port b eight pins, per-bit direction
// - port b direction zero, analog disable one
// - selected analog pin ignores direction and latch
// - selected analog pin reads zero
// - latch writable whatever the direction
// - read gives pin for inputs, latch otherwise
// - port c eight pins, per-bit direction
// - port c direction and latch reset zero
// - sample pins on read, drive after write
package pio_pkg;
	localparam logic [11:0] OFS_A_LATCH  = 12'h000;
	localparam logic [11:0] OFS_A_PIN    = 12'h004;
	localparam logic [11:0] OFS_B_LATCH  = 12'h008;
	localparam logic [11:0] OFS_B_DIR    = 12'h00C;
	localparam logic [11:0] OFS_C_LATCH  = 12'h010;
	localparam logic [11:0] OFS_C_DIR    = 12'h014;
	localparam logic [11:0] OFS_CONV     = 12'h018;
	localparam logic [11:0] OFS_MODE     = 12'h01C;
	localparam logic [11:0] OFS_IRQ_STAT = 12'h020;
	localparam logic [11:0] OFS_IRQ_MASK = 12'h024;
	localparam logic [2:0]  RST_A_LATCH  = 3'h7;
	localparam logic [7:0]  RST_B_DIR    = 8'h00;
	localparam logic [7:0]  RST_B_LATCH  = 8'h00;
	localparam logic [7:0]  RST_C_DIR    = 8'h00;
	localparam logic [7:0]  RST_C_LATCH  = 8'h00;
	localparam logic        RST_ANA_DIS  = 1'h1;
	localparam int          CONV_DIS_BIT = 3;
	localparam int          MODE_DUAL_BIT = 0;
	localparam int          IRQ_EDGE_BIT = 0;
endpackage

// ### core/pio_port.sv
`timescale 1ns/1ns
module pio_port
	import pio_pkg::*;
(
	input  wire logic       clk,
	input  wire logic       arst_n,
	input  wire logic       wr_latch,
	input  wire logic       wr_dir,
	input  wire logic [7:0] wdata,
	input  wire logic [7:0] rst_latch,
	input  wire logic [7:0] rst_dir,
	input  wire logic [7:0] pin_sync,
	input  wire logic [7:0] force_in,
	output logic      [7:0] latch,
	output logic      [7:0] dir,
	output logic      [7:0] rd_mix,
	output logic      [7:0] pad_out,
	output logic      [7:0] pad_oe_n
);
	logic [7:0] next_latch;
	logic [7:0] next_dir;
	logic [7:0] next_pad_out;
	logic [7:0] next_pad_oe_n;
	logic       init;
	logic       next_init;

	always_comb
	begin
		next_init = 1'b1;
		next_latch = init ? latch : rst_latch;
		next_dir   = init ? dir : rst_dir;
		if (init && wr_latch)
			next_latch = wdata;
		if (init && wr_dir)
			next_dir = wdata;
		next_pad_out  = next_latch;
		next_pad_oe_n = ~(next_dir & ~force_in);
		rd_mix = (dir & latch) | (~dir & pin_sync);
	end

	// reset values arrive as constants, taken on first edge
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			init     <= 1'b0;
			latch    <= 8'h00;
			dir      <= 8'h00;
			pad_out  <= 8'h00;
			pad_oe_n <= 8'hFF;
		end
		else
		begin
			init     <= next_init;
			latch    <= next_latch;
			dir      <= next_dir;
			pad_out  <= next_pad_out;
			pad_oe_n <= next_pad_oe_n;
		end
	end
endmodule

// ### core/pio_sync.sv
`timescale 1ns/1ns
module pio_sync
	import pio_pkg::*;
#(
	parameter int W = 8
)(
	input  wire logic         clk,
	input  wire logic         arst_n,
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);
	logic [W-1:0] meta;
	logic [W-1:0] next_meta;
	logic [W-1:0] next_q;

	always_comb
	begin
		next_meta = d;
		next_q    = meta;
	end

	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			meta <= '0;
			q    <= '0;
		end
		else
		begin
			meta <= next_meta;
			q    <= next_q;
		end
	end
endmodule

// ### core/pio_top.sv
`timescale 1ns/1ns
module pio_top
	import pio_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        arst_n,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic             pready,
	output logic      [31:0] prdata,
	output logic             pslverr,
	input  wire logic [2:0]  port_a_in,
	output logic      [2:0]  port_a_out,
	output logic      [2:0]  port_a_oe_n,
	input  wire logic [7:0]  port_b_in,
	output logic      [7:0]  port_b_out,
	output logic      [7:0]  port_b_oe_n,
	input  wire logic [7:0]  port_c_in,
	output logic      [7:0]  port_c_out,
	output logic      [7:0]  port_c_oe_n,
	output logic             low_osc_en,
	output logic             port_a_irq_req,
	output logic             irq
);
	logic [2:0]  a_sync;
	logic [7:0]  b_sync;
	logic [7:0]  c_sync;
	logic [2:0]  port_a_out_latch;
	logic [2:0]  next_port_a_out_latch;
	logic [7:0]  port_b_direction;
	logic [7:0]  port_b_out_latch;
	logic [7:0]  port_b_mix;
	logic [7:0]  port_c_direction;
	logic [7:0]  port_c_latch;
	logic [7:0]  port_c_mix;
	logic [7:0]  b_ana_sel;
	logic [7:0]  b_pad_out;
	logic [7:0]  b_pad_oe_n;
	logic [7:0]  c_pad_out;
	logic [7:0]  c_pad_oe_n;
	logic        analog_disable;
	logic [2:0]  analog_channel_select;
	logic        dual_mode;
	logic        irq_stat;
	logic        irq_mask;
	logic        a0_prev;
	logic        next_analog_disable;
	logic [2:0]  next_analog_channel_select;
	logic        next_dual_mode;
	logic        next_irq_stat;
	logic        next_irq_mask;
	logic        next_a0_prev;
	logic        a_init;
	logic [2:0]  next_port_a_out;
	logic [2:0]  next_port_a_oe_n;
	logic        next_irq;
	logic        next_req;
	logic        next_pready;
	logic [31:0] next_prdata;
	logic        next_pslverr;
	logic        setup;
	logic        wr;
	logic        rd;
	logic        hit;
	logic        a0_fall;
	logic [7:0]  b_read;

	// reads answer from setup; writes land at the completing edge
	assign setup = psel && !penable;
	assign wr    = psel && penable && pready && pwrite;
	assign rd    = setup && !pwrite;

	pio_sync #(.W(3)) u_sync_a (.clk(clk), .arst_n(arst_n),
		.d(port_a_in), .q(a_sync));
	pio_sync #(.W(8)) u_sync_b (.clk(clk), .arst_n(arst_n),
		.d(port_b_in), .q(b_sync));
	pio_sync #(.W(8)) u_sync_c (.clk(clk), .arst_n(arst_n),
		.d(port_c_in), .q(c_sync));

	always_comb
	begin
		b_ana_sel = 8'h00;
		if (!analog_disable)
			b_ana_sel[analog_channel_select] = 1'b1;
	end

	pio_port u_port_b (
		.clk       (clk),
		.arst_n    (arst_n),
		.wr_latch  (wr && paddr == OFS_B_LATCH),
		.wr_dir    (wr && paddr == OFS_B_DIR),
		.wdata     (pwdata[7:0]),
		.rst_latch (RST_B_LATCH),
		.rst_dir   (RST_B_DIR),
		.pin_sync  (b_sync),
		.force_in  (b_ana_sel),
		.latch     (port_b_out_latch),
		.dir       (port_b_direction),
		.rd_mix    (port_b_mix),
		.pad_out   (b_pad_out),
		.pad_oe_n  (b_pad_oe_n)
	);

	pio_port u_port_c (
		.clk       (clk),
		.arst_n    (arst_n),
		.wr_latch  (wr && paddr == OFS_C_LATCH),
		.wr_dir    (wr && paddr == OFS_C_DIR),
		.wdata     (pwdata[7:0]),
		.rst_latch (RST_C_LATCH),
		.rst_dir   (RST_C_DIR),
		.pin_sync  (c_sync),
		.force_in  (8'h00),
		.latch     (port_c_latch),
		.dir       (port_c_direction),
		.rd_mix    (port_c_mix),
		.pad_out   (c_pad_out),
		.pad_oe_n  (c_pad_oe_n)
	);

	assign port_b_out  = b_pad_out;
	assign port_b_oe_n = b_pad_oe_n;
	assign port_c_out  = c_pad_out;
	assign port_c_oe_n = c_pad_oe_n;

	// analog-selected pin reads zero
	assign b_read  = port_b_mix & ~b_ana_sel;
	// own output's falling edge also counts
	assign a0_fall = a0_prev && !a_sync[0];

	always_comb
	begin
		hit = 1'b1;
		next_prdata = 32'h0000_0000;
		unique case (paddr)
			OFS_A_LATCH:  next_prdata[2:0] = port_a_out_latch;
			OFS_A_PIN:    next_prdata[2:0] = a_sync;
			OFS_B_LATCH:  next_prdata[7:0] = b_read;
			OFS_B_DIR:    next_prdata[7:0] = port_b_direction;
			OFS_C_LATCH:  next_prdata[7:0] = port_c_mix;
			OFS_C_DIR:    next_prdata[7:0] = port_c_direction;
			OFS_CONV:     next_prdata[3:0] = {analog_disable,
				analog_channel_select};
			OFS_MODE:     next_prdata[0] = dual_mode;
			OFS_IRQ_STAT: next_prdata[0] = irq_stat;
			OFS_IRQ_MASK: next_prdata[0] = irq_mask;
			default:      hit = 1'b0;
		endcase
		// upper bits of port a reads left at zero, allowed as undefined
		next_pready  = setup;
		next_pslverr = setup && !hit;
		if (!rd)
			next_prdata = prdata;
	end

	always_comb
	begin
		next_port_a_out_latch      = a_init ? port_a_out_latch
			: RST_A_LATCH;
		next_analog_disable        = analog_disable;
		next_analog_channel_select = analog_channel_select;
		next_dual_mode             = dual_mode;
		next_irq_mask              = irq_mask;
		next_irq_stat              = irq_stat;
		if (rd && paddr == OFS_IRQ_STAT)
			next_irq_stat = 1'b0;
		if (wr)
		begin
			unique case (paddr)
				OFS_A_LATCH:  next_port_a_out_latch = pwdata[2:0];
				OFS_CONV:
				begin
					next_analog_disable = pwdata[CONV_DIS_BIT];
					next_analog_channel_select = pwdata[2:0];
				end
				OFS_MODE:     next_dual_mode = pwdata[MODE_DUAL_BIT];
				OFS_IRQ_MASK: next_irq_mask = pwdata[IRQ_EDGE_BIT];
				default:      ;
			endcase
		end
		if (a0_fall)
			next_irq_stat = 1'b1; // set wins over read clear
		next_a0_prev = a_sync[0];
		next_req     = a0_fall;
		next_irq     = next_irq_stat && next_irq_mask;
		// open-drain style: latch one releases the pin
		next_port_a_out  = next_port_a_out_latch;
		next_port_a_oe_n = next_port_a_out_latch;
		if (next_dual_mode)
			next_port_a_oe_n[2:1] = 2'h3;
	end

	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			a_init                <= 1'b0;
			port_a_out_latch      <= RST_A_LATCH;
			analog_disable        <= RST_ANA_DIS;
			analog_channel_select <= 3'h0;
			dual_mode             <= 1'b0;
			irq_stat              <= 1'b0;
			irq_mask              <= 1'b0;
			a0_prev               <= 1'b0;
			port_a_out            <= RST_A_LATCH;
			port_a_oe_n           <= 3'h7;
			low_osc_en            <= 1'b0;
			port_a_irq_req        <= 1'b0;
			irq                   <= 1'b0;
			pready                <= 1'b0;
			pslverr               <= 1'b0;
			prdata                <= 32'h0000_0000;
		end
		else
		begin
			a_init                <= 1'b1;
			port_a_out_latch      <= next_port_a_out_latch;
			analog_disable        <= next_analog_disable;
			analog_channel_select <= next_analog_channel_select;
			dual_mode             <= next_dual_mode;
			irq_stat              <= next_irq_stat;
			irq_mask              <= next_irq_mask;
			a0_prev               <= next_a0_prev;
			port_a_out            <= next_port_a_out;
			port_a_oe_n           <= next_port_a_oe_n;
			low_osc_en            <= next_dual_mode;
			port_a_irq_req        <= next_req;
			irq                   <= next_irq;
			pready                <= next_pready;
			pslverr               <= next_pslverr;
			prdata                <= next_prdata;
		end
	end

	a_irq_on_fall: assert property (@(posedge clk)
		disable iff (!arst_n)
		(a_sync[0] == 1'b0 && $past(a_sync[0])) |=> irq_stat)
		else $error("fall on pin zero did not set status");
	a_a_latch_reset: assert property (@(posedge clk)
		disable iff (!arst_n)
		$rose(a_init) |-> port_a_out_latch == RST_A_LATCH)
		else $error("port a latch not all ones after reset");
	a_ana_reads_zero: assert property (@(posedge clk)
		disable iff (!arst_n)
		(!analog_disable && rd && paddr == OFS_B_LATCH)
		|=> prdata[analog_channel_select] == 1'b0)
		else $error("analog pin read not zero");
	a_ana_no_drive: assert property (@(posedge clk)
		disable iff (!arst_n)
		(!analog_disable && $stable(analog_disable)
		&& $stable(analog_channel_select))
		|-> port_b_oe_n[analog_channel_select])
		else $error("analog pin driven");
	a_apb_one_wait: assert property (@(posedge clk)
		disable iff (!arst_n)
		setup |=> pready ##1 !pready)
		else $error("apb answer not one cycle");
	a_c_drive_dir: assert property (@(posedge clk)
		disable iff (!arst_n)
		(wr && paddr == OFS_C_DIR) |=> ##1
		port_c_oe_n == ~$past(pwdata[7:0], 2))
		else $error("port c enable not following direction");
	a_osc_pins_free: assert property (@(posedge clk)
		disable iff (!arst_n)
		low_osc_en |-> port_a_oe_n[2:1] == 2'h3)
		else $error("oscillator pins driven in dual mode");
	a_a_pin_read: assert property (@(posedge clk)
		disable iff (!arst_n)
		(rd && paddr == OFS_A_PIN) |=> prdata[2:0] == $past(a_sync))
		else $error("pin level read wrong");
	a_b_mix_read: assert property (@(posedge clk)
		disable iff (!arst_n)
		(rd && paddr == OFS_B_LATCH && analog_disable) |=>
		prdata[7:0] == $past(port_b_mix))
		else $error("port b read mix wrong");
	a_irq_level: assert property (@(posedge clk)
		disable iff (!arst_n)
		irq == (irq_stat && irq_mask))
		else $error("interrupt output not status and mask");
	a_req_pulse: assert property (@(posedge clk)
		disable iff (!arst_n)
		port_a_irq_req |=> !port_a_irq_req)
		else $error("pin zero request longer than one cycle");
	a_a_write_latch: assert property (@(posedge clk)
		disable iff (!arst_n)
		(wr && paddr == OFS_A_LATCH) |=>
		port_a_out_latch == $past(pwdata[2:0]))
		else $error("port a latch write lost");
	a_a_open_drain: assert property (@(posedge clk)
		disable iff (!arst_n)
		(~port_a_oe_n & port_a_out) == 3'h0)
		else $error("port a drives a high level");
	a_b_dir_drive: assert property (@(posedge clk)
		disable iff (!arst_n)
		(wr && paddr == OFS_B_DIR && analog_disable) |=>
		port_b_oe_n == ~$past(pwdata[7:0]))
		else $error("port b enable not following direction");
	a_b_reset_input: assert property (@(posedge clk)
		disable iff (!arst_n)
		$rose(a_init) |-> port_b_direction == RST_B_DIR
		&& analog_disable == RST_ANA_DIS)
		else $error("port b not all inputs after reset");
	a_c_reset_input: assert property (@(posedge clk)
		disable iff (!arst_n)
		$rose(a_init) |-> port_c_oe_n == 8'hFF
		&& port_c_latch == RST_C_LATCH)
		else $error("port c not all inputs after reset");
	a_err_with_ready: assert property (@(posedge clk)
		disable iff (!arst_n)
		pslverr |-> pready)
		else $error("error response without ready");
endmodule

// ### sim/pio_pins.sv
`timescale 1ns/1ns
module pio_pins
(
	input  wire logic [2:0] a_out,
	input  wire logic [2:0] a_oe_n,
	input  wire logic [2:0] a_ext,
	input  wire logic [2:0] a_ext_en,
	input  wire logic [7:0] b_out,
	input  wire logic [7:0] b_oe_n,
	input  wire logic [7:0] b_ext,
	input  wire logic [7:0] c_out,
	input  wire logic [7:0] c_oe_n,
	input  wire logic [7:0] c_ext,
	output logic      [2:0] a_lvl,
	output logic      [7:0] b_lvl,
	output logic      [7:0] c_lvl
);
	// released port a lines float high on the pull-up
	assign a_lvl = (~a_oe_n & a_out) | (a_oe_n & ~a_ext_en)
		| (a_oe_n & a_ext_en & a_ext);
	assign b_lvl = (~b_oe_n & b_out) | (b_oe_n & b_ext);
	assign c_lvl = (~c_oe_n & c_out) | (c_oe_n & c_ext);
endmodule

// ### sim/pio_top_tb.sv
`timescale 1ns/1ns
module pio_top_tb
	import pio_pkg::*;
;
	logic        clk, arst_n, psel, penable, pwrite, pready, pslverr;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, q;
	logic [2:0]  a_lvl, a_out, a_oe_n, a_ext, a_ext_en;
	logic [7:0]  b_lvl, b_out, b_oe_n, b_ext, c_lvl, c_out, c_oe_n, c_ext;
	logic        low_osc_en, a_irq_req, irq, e;
	int          err_count, checked, cyc;
	pio_top pio_top_inst (.clk(clk), .arst_n(arst_n), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .pready(pready), .prdata(prdata),
		.pslverr(pslverr), .port_a_in(a_lvl), .port_a_out(a_out),
		.port_a_oe_n(a_oe_n), .port_b_in(b_lvl), .port_b_out(b_out),
		.port_b_oe_n(b_oe_n), .port_c_in(c_lvl), .port_c_out(c_out),
		.port_c_oe_n(c_oe_n), .low_osc_en(low_osc_en),
		.port_a_irq_req(a_irq_req), .irq(irq));
	pio_pins pio_pins_inst (.a_out(a_out), .a_oe_n(a_oe_n), .a_ext(a_ext),
		.a_ext_en(a_ext_en), .b_out(b_out), .b_oe_n(b_oe_n),
		.b_ext(b_ext), .c_out(c_out), .c_oe_n(c_oe_n), .c_ext(c_ext),
		.a_lvl(a_lvl), .b_lvl(b_lvl), .c_lvl(c_lvl));
	task automatic final_report();
		$display("checks %0d mismatches %0d", checked, err_count);
		if (err_count == 0 && checked > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task automatic chk(input string s, input logic [31:0] x, y);
		checked++;
		if (x !== y)
		begin
			err_count++;
			$display("Error %s expected %h seen %h", s, x, y);
		end
	endtask
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge clk);
		penable <= 1'b1;
		do
		begin
			@(posedge clk);
			n++;
		end
		while (pready !== 1'b1);
		chk("access cycles", 32'h1, n);
		q = prdata;
		e = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic rdc(input string s, input logic [11:0] a,
		input logic [31:0] x);
		apb(1'b0, a, 32'h0);
		chk(s, x, q);
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask
	initial
	begin
		clk = 1'b0;
		forever
			#10 clk = ~clk;
	end
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			err_count++;
			final_report();
		end
	end
	initial
	begin
		arst_n = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0;
		a_ext = 3'h0;
		a_ext_en = 3'h0;
		b_ext = 8'hA5;
		c_ext = 8'h33;
		repeat (20) @(posedge clk);
		arst_n <= 1'b1;
		repeat (2) @(posedge clk);
		rdc("a latch", OFS_A_LATCH, 32'h7);
		rdc("b dir", OFS_B_DIR, 32'h0);
		rdc("conv", OFS_CONV, 32'h8);
		rdc("c dir", OFS_C_DIR, 32'h0);
		rdc("c data", OFS_C_LATCH, 32'h33);
		chk("c oe_n", 32'hFF, {24'h0, c_oe_n});
		$display("test reset done");
		wr(OFS_C_LATCH, 32'h5A);
		repeat (2) @(posedge clk);
		chk("c oe_n", 32'hFF, {24'h0, c_oe_n});
		wr(OFS_C_DIR, 32'hF0);
		repeat (4) @(posedge clk);
		chk("c oe_n", 32'h0F, {24'h0, c_oe_n});
		chk("c out", 32'h5A, {24'h0, c_out});
		rdc("c data", OFS_C_LATCH, 32'h53);
		$display("test port c done");
		wr(OFS_B_LATCH, 32'hFF);
		wr(OFS_B_DIR, 32'h0F);
		for (int ch = 0; ch < 8; ch++)
		begin
			wr(OFS_CONV, ch);
			repeat (4) @(posedge clk);
			chk("b oe_n", {24'h0, ~(8'h0F & ~(8'h01 << ch))},
				{24'h0, b_oe_n});
			rdc("b data", OFS_B_LATCH,
				{24'h0, 8'hAF & ~(8'h01 << ch)});
		end
		wr(OFS_CONV, 32'h8);
		repeat (4) @(posedge clk);
		chk("b oe_n", 32'hF0, {24'h0, b_oe_n});
		rdc("b data", OFS_B_LATCH, 32'hAF);
		$display("test port b done");
		wr(OFS_MODE, 32'h1);
		wr(OFS_A_LATCH, 32'h0);
		repeat (3) @(posedge clk);
		chk("osc en", 32'h1, {31'h0, low_osc_en});
		chk("a oe_n", 32'h6, {29'h0, a_oe_n});
		wr(OFS_MODE, 32'h0);
		repeat (3) @(posedge clk);
		chk("a oe_n", 32'h0, {29'h0, a_oe_n});
		rdc("irq stat", OFS_IRQ_STAT, 32'h1);
		chk("irq", 32'h0, {31'h0, irq});
		wr(OFS_A_LATCH, 32'h7);
		a_ext_en <= 3'h2;
		repeat (4) @(posedge clk);
		rdc("a pins", OFS_A_PIN, 32'h5);
		rdc("a latch", OFS_A_LATCH, 32'h7);
		rdc("irq stat", OFS_IRQ_STAT, 32'h0);
		wr(OFS_IRQ_MASK, 32'h1);
		wr(OFS_A_LATCH, 32'h6);
		repeat (4) @(posedge clk);
		chk("irq", 32'h1, {31'h0, irq});
		rdc("a pins", OFS_A_PIN, 32'h4);
		rdc("irq stat", OFS_IRQ_STAT, 32'h1);
		repeat (2) @(posedge clk);
		chk("irq", 32'h0, {31'h0, irq});
		$display("test port a done");
		apb(1'b0, 12'h030, 32'h0);
		chk("unmapped data", 32'h0, q);
		chk("unmapped err", 32'h1, {31'h0, e});
		$display("test unmapped done");
		final_report();
	end
endmodule
